// *** hw/siof_top.v ***
// Servo I/O function map: input decode, status outputs, APB registers
`timescale 1ns/100ps
`default_nettype none
`include "siof_regs.vh"
module siof_top #(
    parameter NIN = 11,
    parameter SW = 16,
    parameter PW = 32
) (
    // APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Terminals, one per input function, asynchronous
    input wire [NIN-1:0] terminal_in,
    // Drive state
    input wire signed [SW-1:0] speed_filtered,
    input wire signed [SW-1:0] speed_feedback,
    input wire signed [SW-1:0] speed_reference,
    input wire signed [PW-1:0] present_position,
    input wire pulse_ref_in,
    input wire cmd_done_set,
    input wire pos_done_set,
    // Decoded functions
    output reg homing_go_input,
    output reg xint_inhibit_out,
    output reg emergency_stop_out,
    output reg position_lock_out,
    output reg deviation_clear_input,
    output reg speed_limit_source_select,
    output reg [SW-1:0] speed_limit_active,
    output reg pulse_accept_out,
    output reg axis_command_write_with_irq,
    output reg axis_command_write_no_irq,
    output reg axis_write_irq_out,
    output reg command_done_clear,
    output reg capture_home_here,
    output reg home_switch_out,
    output reg cmd_done_out,
    output reg pos_done_out,
    output reg [PW-1:0] home_position,
    // Status outputs
    output reg servo_ready_out,
    output reg motor_rotating_out,
    output reg zero_speed_out,
    output reg irq
);
    function [2:0] force_level;
        input [2:0] cfg;
        begin
            if (cfg == `SIOF_LOGIC_RISE)
                force_level = `SIOF_LOGIC_HIGH;
            else if (cfg == `SIOF_LOGIC_FALL || cfg == `SIOF_LOGIC_BOTH)
                force_level = `SIOF_LOGIC_LOW;
            else
                force_level = cfg;
        end
    endfunction

    function [SW-1:0] mag;
        input signed [SW-1:0] v;
        begin
            mag = v[SW-1] ? (~v + 1'b1) : v;
        end
    endfunction

    reg [NIN-1:0] sync1_reg, sync2_reg, func_reg;
    reg [5:0] ctrl_reg;
    // One 32-bit word holds all logic fields; the last field has only two bits,
    // so that input accepts codes 0 to 3 and never code 4
    reg [31:0] logic_reg;
    reg [SW-1:0] lim1_reg, lim2_reg, rotth_reg, zeroth_reg;
    reg [3:0] status_reg, irqen_reg;
    reg [3:0] ev_next;
    reg [NIN-1:0] act_next;
    reg [3*NIN-1:0] eff_logic;
    reg [2:0] lg;
    reg pulse_d_reg;
    // Zero padding lets every field be sliced the same way, whatever NIN is
    wire [3*NIN+31:0] logic_all = {{3*NIN{1'b0}}, logic_reg};
    wire [3*NIN+31:0] eff_all = {32'h0000_0000, eff_logic};
    // Terminal level that reads inactive under the reset logic (active low)
    localparam [NIN-1:0] TERM_IDLE = {NIN{1'b1}};
    wire [1:0] pos_src = ctrl_reg[`SIOF_CTRL_SRC_MSB:`SIOF_CTRL_SRC_LSB];
    wire pulse_src = pos_src == `SIOF_SRC_PULSE;
    wire multi_src = pos_src == `SIOF_SRC_MULTI;
    wire posmode = ctrl_reg[`SIOF_CTRL_POSMODE];
    wire signed [SW:0] spd_diff = {speed_feedback[SW-1], speed_feedback} -
        {speed_reference[SW-1], speed_reference};
    wire [SW:0] diff_mag = spd_diff[SW] ? (~spd_diff + 1'b1) : spd_diff;
    // Setup-phase strobes, then access-phase write enables; reads are answered from the setup edge, so no wait state
    wire setup_rd = psel && !penable && !pwrite;
    wire setup_wr = psel && !penable && pwrite;
    wire wr_en = psel && penable && pwrite && pready;
    wire clr_wr = wr_en && paddr == `SIOF_IRQCLR_OFF;
    // Magnitudes for the lock (feedback) and rotation (filtered) compares
    wire [SW-1:0] fb_mag = mag(speed_feedback);
    wire [SW-1:0] filt_mag = mag(speed_filtered);
    integer i;

    // Polarity after forcing every input to a level setting
    always @* begin
        eff_logic = {3*NIN{1'b0}};
        act_next = {NIN{1'b0}};
        lg = 3'h0;
        for (i = 0; i < NIN; i = i + 1) begin
            lg = force_level(logic_all[3*i +: 3]);
            eff_logic[3*i +: 3] = lg;
            act_next[i] = (lg == `SIOF_LOGIC_HIGH) ? sync2_reg[i] : ~sync2_reg[i];
        end
    end

    // Synchroniser; first stage only feeds the second
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Idle level, so no false function edge follows reset
            sync1_reg <= TERM_IDLE;
            sync2_reg <= TERM_IDLE;
            func_reg <= {NIN{1'b0}};
        end else begin
            sync1_reg <= terminal_in;
            sync2_reg <= sync1_reg;
            func_reg <= act_next;
        end
    end

    // Events are rising edges of decoded levels against the registered copy
    always @* begin
        ev_next = 4'h0;
        ev_next[`SIOF_EV_WRIRQ] = act_next[`SIOF_IN_WRIRQ] & ~func_reg[`SIOF_IN_WRIRQ] & posmode & multi_src;
        ev_next[`SIOF_EV_HOMEREC] = act_next[`SIOF_IN_HOMEREC] & ~func_reg[`SIOF_IN_HOMEREC];
        ev_next[`SIOF_EV_ESTOP] = act_next[`SIOF_IN_ESTOP] & ~func_reg[`SIOF_IN_ESTOP];
        ev_next[`SIOF_EV_CMDCLR] = act_next[`SIOF_IN_CMDCLR] & ~func_reg[`SIOF_IN_CMDCLR];
    end

    // Function outputs, all low through reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            homing_go_input <= 1'b0;
            xint_inhibit_out <= 1'b0;
            emergency_stop_out <= 1'b0;
            position_lock_out <= 1'b0;
            deviation_clear_input <= 1'b0;
            speed_limit_source_select <= 1'b0;
            speed_limit_active <= {SW{1'b0}};
            pulse_accept_out <= 1'b0;
            pulse_d_reg <= 1'b0;
            axis_command_write_with_irq <= 1'b0;
            axis_command_write_no_irq <= 1'b0;
            axis_write_irq_out <= 1'b0;
            command_done_clear <= 1'b0;
            capture_home_here <= 1'b0;
            home_switch_out <= 1'b0;
            cmd_done_out <= 1'b0;
            pos_done_out <= 1'b0;
            home_position <= {PW{1'b0}};
            servo_ready_out <= 1'b0;
            motor_rotating_out <= 1'b0;
            zero_speed_out <= 1'b0;
        end else begin
            homing_go_input <= act_next[`SIOF_IN_HOMING];
            xint_inhibit_out <= act_next[`SIOF_IN_XINH];
            emergency_stop_out <= act_next[`SIOF_IN_ESTOP];
            // Lock only once the motor is down to zero speed
            position_lock_out <= act_next[`SIOF_IN_ESTOP] &&
                fb_mag <= zeroth_reg;
            deviation_clear_input <= act_next[`SIOF_IN_DEVCLR];
            speed_limit_source_select <= act_next[`SIOF_IN_LIMSEL];
            speed_limit_active <= act_next[`SIOF_IN_LIMSEL] ? lim2_reg : lim1_reg;
            pulse_d_reg <= pulse_ref_in;
            // Pulses pass only when not inhibited in pulse source mode
            pulse_accept_out <= pulse_d_reg &&
                !(posmode && pulse_src && act_next[`SIOF_IN_PINH]);
            axis_command_write_with_irq <= act_next[`SIOF_IN_WRIRQ] & posmode & multi_src;
            axis_command_write_no_irq <= act_next[`SIOF_IN_WRNOIRQ] & posmode & multi_src;
            axis_write_irq_out <= ev_next[`SIOF_EV_WRIRQ];
            command_done_clear <= act_next[`SIOF_IN_CMDCLR];
            capture_home_here <= act_next[`SIOF_IN_HOMEREC];
            home_switch_out <= act_next[`SIOF_IN_HOMESW];
            // Clear holds while the input is active, beating any set
            if (act_next[`SIOF_IN_CMDCLR]) begin
                cmd_done_out <= 1'b0;
                pos_done_out <= 1'b0;
            end else begin
                if (cmd_done_set)
                    cmd_done_out <= 1'b1;
                if (pos_done_set)
                    pos_done_out <= 1'b1;
            end
            if (ev_next[`SIOF_EV_HOMEREC])
                home_position <= present_position;
            servo_ready_out <= ctrl_reg[`SIOF_CTRL_READY];
            motor_rotating_out <= filt_mag >= rotth_reg;
            // One bit wider than the speeds, so the difference of two extremes cannot wrap
            zero_speed_out <= diff_mag <= {1'b0, zeroth_reg};
        end
    end

    // APB register file; zero wait states
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= 6'h00;
            logic_reg <= 32'h0000_0000;
            lim1_reg <= {SW{1'b0}};
            lim2_reg <= {SW{1'b0}};
            rotth_reg <= {SW{1'b0}};
            zeroth_reg <= {SW{1'b0}};
            status_reg <= 4'h0;
            irqen_reg <= 4'h0;
            irq <= 1'b0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (wr_en) begin
                if (paddr == `SIOF_CTRL_OFF)
                    ctrl_reg <= pwdata[5:0];
                else if (paddr == `SIOF_LOGIC_OFF)
                    logic_reg <= pwdata;
                else if (paddr == `SIOF_LIMIT1_OFF)
                    lim1_reg <= pwdata[SW-1:0];
                else if (paddr == `SIOF_LIMIT2_OFF)
                    lim2_reg <= pwdata[SW-1:0];
                else if (paddr == `SIOF_ROTTH_OFF)
                    rotth_reg <= pwdata[SW-1:0];
                else if (paddr == `SIOF_ZEROTH_OFF)
                    zeroth_reg <= pwdata[SW-1:0];
                else if (paddr == `SIOF_IRQEN_OFF)
                    irqen_reg <= pwdata[3:0];
            end
            // New events win over a same-cycle clear
            if (clr_wr)
                status_reg <= (status_reg & ~pwdata[3:0]) | ev_next;
            else
                status_reg <= status_reg | ev_next;
            // Interrupt follows status one cycle later, straight from a flip-flop
            irq <= |(status_reg & irqen_reg);
            if (setup_rd) begin
                prdata <= 32'h0000_0000;
                if (paddr == `SIOF_CTRL_OFF)
                    prdata[5:0] <= ctrl_reg;
                else if (paddr == `SIOF_LOGIC_OFF)
                    prdata <= logic_reg;
                else if (paddr == `SIOF_EFFLOGIC_OFF)
                    prdata <= eff_all[31:0];
                else if (paddr == `SIOF_FUNC_OFF)
                    prdata[NIN-1:0] <= func_reg;
                else if (paddr == `SIOF_LIMIT1_OFF)
                    prdata[SW-1:0] <= lim1_reg;
                else if (paddr == `SIOF_LIMIT2_OFF)
                    prdata[SW-1:0] <= lim2_reg;
                else if (paddr == `SIOF_ROTTH_OFF)
                    prdata[SW-1:0] <= rotth_reg;
                else if (paddr == `SIOF_ZEROTH_OFF)
                    prdata[SW-1:0] <= zeroth_reg;
                else if (paddr == `SIOF_SPEED_OFF)
                    prdata[2:0] <= {zero_speed_out, motor_rotating_out, servo_ready_out};
                else if (paddr == `SIOF_HOME_OFF)
                    prdata[PW-1:0] <= home_position;
                else if (paddr == `SIOF_STATUS_OFF)
                    prdata[3:0] <= status_reg;
                else if (paddr == `SIOF_IRQEN_OFF)
                    prdata[3:0] <= irqen_reg;
                else if (paddr == `SIOF_ACTLIM_OFF)
                    prdata[SW-1:0] <= speed_limit_active;
                else
                    pslverr <= 1'b1;
            end else if (setup_wr) begin
                // Read-only, unmapped and unaligned words refuse writes without effect
                if (paddr > `SIOF_ACTLIM_OFF || paddr[1:0] != 2'h0 || paddr == `SIOF_EFFLOGIC_OFF ||
                    paddr == `SIOF_FUNC_OFF || paddr == `SIOF_SPEED_OFF || paddr == `SIOF_HOME_OFF ||
                    paddr == `SIOF_STATUS_OFF || paddr == `SIOF_ACTLIM_OFF)
                    pslverr <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// *** hw/siof_regs.vh ***
// Register offsets, field positions and codes of the servo I/O function map
`ifndef SIOF_REGS_VH
`define SIOF_REGS_VH
// Register byte offsets
`define SIOF_CTRL_OFF 12'h000
`define SIOF_LOGIC_OFF 12'h004
`define SIOF_EFFLOGIC_OFF 12'h008
`define SIOF_FUNC_OFF 12'h00c
`define SIOF_LIMIT1_OFF 12'h010
`define SIOF_LIMIT2_OFF 12'h014
`define SIOF_ROTTH_OFF 12'h018
`define SIOF_ZEROTH_OFF 12'h01c
`define SIOF_SPEED_OFF 12'h020
`define SIOF_HOME_OFF 12'h024
`define SIOF_STATUS_OFF 12'h028
`define SIOF_IRQEN_OFF 12'h02c
`define SIOF_IRQCLR_OFF 12'h030
`define SIOF_ACTLIM_OFF 12'h034
// Control register fields
`define SIOF_CTRL_POSMODE 0
`define SIOF_CTRL_READY 1
`define SIOF_CTRL_SRC_LSB 4
`define SIOF_CTRL_SRC_MSB 5
// Position source codes
`define SIOF_SRC_PULSE 2'h0
`define SIOF_SRC_MULTI 2'h2
// Terminal logic codes, 3 bits per input
`define SIOF_LOGIC_LOW 3'h0
`define SIOF_LOGIC_HIGH 3'h1
`define SIOF_LOGIC_RISE 3'h2
`define SIOF_LOGIC_FALL 3'h3
`define SIOF_LOGIC_BOTH 3'h4
// Input function bit positions
`define SIOF_IN_HOMING 0
`define SIOF_IN_XINH 1
`define SIOF_IN_ESTOP 2
`define SIOF_IN_DEVCLR 3
`define SIOF_IN_LIMSEL 4
`define SIOF_IN_PINH 5
`define SIOF_IN_WRIRQ 6
`define SIOF_IN_WRNOIRQ 7
`define SIOF_IN_CMDCLR 8
`define SIOF_IN_HOMEREC 9
`define SIOF_IN_HOMESW 10
// Status event bit positions
`define SIOF_EV_WRIRQ 0
`define SIOF_EV_HOMEREC 1
`define SIOF_EV_ESTOP 2
`define SIOF_EV_CMDCLR 3
`endif

// *** test/siof_assertions.sv ***
// Checker of the servo I/O function map
`timescale 1ns/100ps
`default_nettype none
module siof_checker (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Drive state
    input wire logic signed [15:0] speed_filtered,
    input wire logic signed [15:0] speed_feedback,
    input wire logic signed [15:0] speed_reference,
    // Outputs
    input wire logic emergency_stop_out,
    input wire logic position_lock_out,
    input wire logic axis_write_irq_out,
    input wire logic command_done_clear,
    input wire logic cmd_done_out,
    input wire logic pos_done_out,
    input wire logic servo_ready_out,
    input wire logic motor_rotating_out,
    input wire logic zero_speed_out,
    input wire logic irq
);
    logic [31:0] sn [0:7];
    logic [7:0] wr;
    wire signed [16:0] fs = speed_filtered;
    wire signed [16:0] fd = speed_feedback - speed_reference;
    wire [16:0] fa = fs < 0 ? -fs : fs;
    wire [16:0] da = fd < 0 ? -fd : fd;
    wire [15:0] rth = sn[6][15:0];
    wire [15:0] zth = sn[7][15:0];
    wire rdy = sn[0][1];
    // Shadow of settings; trusted only once written after the last reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr <= 8'h00;
        end else if (psel && penable && pready && pwrite && !pslverr && paddr < 12'h020) begin
            sn[paddr[4:2]] <= pwdata;
            wr[paddr[4:2]] <= 1'b1;
        end
    end
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_ready_one: assert property (psel && !penable |=> pready)
        else $error("pready missing in access phase");
    a_reset_quiet: assert property ($rose(presetn) |-> !irq && !servo_ready_out && !motor_rotating_out)
        else $error("output active after reset");
    a_reset_funcs: assert property ($rose(presetn) |=> !emergency_stop_out && !command_done_clear)
        else $error("function active after reset");
    a_lock_estop: assert property (position_lock_out |-> emergency_stop_out)
        else $error("position lock without stop");
    a_irq_pulse: assert property (axis_write_irq_out |=> !axis_write_irq_out)
        else $error("write interrupt longer than one cycle");
    a_clear_done: assert property (command_done_clear [*2] |-> !cmd_done_out && !pos_done_out)
        else $error("done state kept during clear");
    a_rot_thresh: assert property (wr[6] && $stable(fs) && $stable(rth) |-> motor_rotating_out == (fa >= rth))
        else $error("rotation output wrong");
    a_zero_thresh: assert property (wr[7] && $stable(fd) && $stable(zth) |-> zero_speed_out == (da <= zth))
        else $error("zero speed output wrong");
    a_ready_mirror: assert property (wr[0] && $stable(rdy) |-> servo_ready_out == rdy)
        else $error("ready output wrong");
    c_lock: cover property (position_lock_out);
    c_write_irq: cover property (axis_write_irq_out);
    c_irq: cover property (irq);
endmodule
bind siof_top siof_checker chk_i (.*);
`default_nettype wire

// *** test/siof_host.sv ***
// Host model driving the function terminals as levels
`timescale 1ns/100ps
`default_nettype none
module siof_host (
    // From bench
    input wire logic [10:0] want,
    input wire logic [4:0] lag,
    // Terminals
    output logic [10:0] terminal_in
);
    // Levels held as long as wanted; lag is off the clock grid on purpose
    initial terminal_in = 11'h7ff;
    always @(want) terminal_in <= #(lag) want;
endmodule
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking bench of the servo I/O function map
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pulse_ref_in = 0;
    logic cmd_done_set = 0, pos_done_set = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rs = 32'hee6a427f, lw = 0, ew = 0;
    logic [33:0] q;
    logic [33:0] exp_q [$];
    logic [10:0] want = 11'h7ff;
    logic [4:0] lag = 5'd3;
    logic signed [15:0] speed_filtered = 0, speed_feedback = 0, speed_reference = 0;
    logic signed [15:0] bv [4] = '{100, -100, 99, -101};
    logic signed [31:0] present_position = 0;
    wire [31:0] prdata, home_position;
    wire [15:0] speed_limit_active;
    wire [10:0] terminal_in;
    wire pready, pslverr, homing_go_input, xint_inhibit_out, emergency_stop_out, position_lock_out;
    wire deviation_clear_input, speed_limit_source_select, pulse_accept_out, axis_command_write_with_irq;
    wire axis_command_write_no_irq, axis_write_irq_out, command_done_clear, capture_home_here;
    wire home_switch_out, cmd_done_out, pos_done_out, servo_ready_out, motor_rotating_out, zero_speed_out, irq;
    wire [10:0] fo = {home_switch_out, capture_home_here, command_done_clear, axis_command_write_no_irq,
        axis_command_write_with_irq, 1'b0, speed_limit_source_select, deviation_clear_input, emergency_stop_out,
        xint_inhibit_out, homing_go_input};
    int errors = 0, checked = 0;
    siof_top uut (.*);
    siof_host host (.*);
    always #12.5 pclk = ~pclk;
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int mag(int v);
        return v < 0 ? -v : v;
    endfunction
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic e);
        exp_q.push_back({!w && !e, e, d});
        cyc(1);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        cyc(1);
        penable <= 1;
        do cyc(1); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
    endtask
    // Terminals idle high: reset logic is active low
    task automatic term(int i, logic act);
        cyc(1);
        want[i] <= !act;
        cyc(8);
    endtask
    task give_verdict;
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready) begin
            q = exp_q.pop_front();
            chk("pslverr", q[32], pslverr);
            if (q[33]) chk("prdata", q[31:0], prdata);
        end
    end
    initial begin
        cyc(20000);
        errors++;
        give_verdict();
    end
    initial begin
        cyc(3);
        presetn <= 1;
        apb(0, 12'h028, 0, 0);
        apb(1, 12'h018, 100, 0);
        apb(1, 12'h01c, 10, 0);
        apb(1, 12'h000, 32'h23, 0);
        apb(0, 12'h000, 32'h23, 0);
        apb(1, 12'h0fc, 1, 1);
        apb(1, 12'h00c, 1, 1);
        apb(0, 12'h030, 0, 1);
        for (int i = 0; i < 11; i++) begin
            term(i, 1);
            chk("function outputs", (1 << i) & 32'h7df, fo);
            apb(0, 12'h00c, 1 << i, 0);
            term(i, 0);
        end
        $display("test decode done");
        for (int i = 0; i < 10; i++) begin
            lw[3*i +: 3] = 3'(i % 5);
            ew[3*i +: 3] = 3'(i % 5 == 1 || i % 5 == 2);
        end
        apb(1, 12'h004, lw, 0);
        apb(0, 12'h008, ew, 0);
        cyc(6);
        apb(0, 12'h00c, 32'h0c6, 0);
        want <= 11'h000;
        cyc(8);
        apb(0, 12'h00c, 32'h739, 0);
        apb(1, 12'h004, 0, 0);
        want <= 11'h7ff;
        apb(1, 12'h010, 32'h1234, 0);
        apb(1, 12'h014, 32'h0567, 0);
        cyc(8);
        chk("limit one", 32'h1234, speed_limit_active);
        term(4, 1);
        chk("limit two", 32'h0567, speed_limit_active);
        apb(0, 12'h034, 32'h0567, 0);
        term(4, 0);
        $display("test polarity done");
        for (int i = 0; i < 12; i++) begin
            rs = lfsr(rs);
            cyc(1);
            speed_filtered <= i < 4 ? bv[i] : $signed(rs[8:0]);
            speed_reference <= $signed(rs[20:13]);
            speed_feedback <= $signed(rs[20:13]) + (i < 4 ? bv[i] % 90 : $signed(rs[4:0]));
            cyc(3);
            chk("rotating", mag(speed_filtered) >= 100, motor_rotating_out);
            chk("zero speed", mag(speed_feedback - speed_reference) <= 10, zero_speed_out);
        end
        speed_filtered <= 0;
        speed_feedback <= 0;
        speed_reference <= 0;
        apb(1, 12'h030, 32'hf, 0);
        apb(1, 12'h02c, 32'h2, 0);
        lag <= 5'd29;
        rs = lfsr(rs);
        present_position <= rs;
        term(9, 1);
        chk("home position", rs, home_position);
        chk("irq raised", 1, irq);
        apb(0, 12'h028, 32'h2, 0);
        apb(1, 12'h02c, 0, 0);
        cyc(2);
        chk("irq masked", 0, irq);
        apb(1, 12'h02c, 32'h2, 0);
        apb(1, 12'h030, 32'h2, 0);
        cyc(2);
        chk("irq cleared", 0, irq);
        term(9, 0);
        $display("test speed and home done");
        term(6, 1);
        chk("write irq", 1, axis_command_write_with_irq);
        term(6, 0);
        term(7, 1);
        chk("write", 1, axis_command_write_no_irq);
        apb(1, 12'h000, 32'h01, 0);
        cyc(2);
        chk("write gated", 0, axis_command_write_no_irq);
        chk("ready dropped", 0, servo_ready_out);
        term(7, 0);
        pulse_ref_in <= 1;
        cyc(3);
        chk("pulse taken", 1, pulse_accept_out);
        term(5, 1);
        chk("pulse ignored", 0, pulse_accept_out);
        term(5, 0);
        term(1, 1);
        chk("inhibit", 1, xint_inhibit_out);
        term(1, 0);
        term(2, 1);
        chk("position lock", 1, position_lock_out);
        term(2, 0);
        cmd_done_set <= 1;
        pos_done_set <= 1;
        cyc(1);
        cmd_done_set <= 0;
        pos_done_set <= 0;
        cyc(2);
        chk("command done", 1, cmd_done_out);
        chk("position done", 1, pos_done_out);
        term(8, 1);
        chk("command cleared", 0, cmd_done_out);
        chk("position cleared", 0, pos_done_out);
        term(8, 0);
        $display("test functions done");
        give_verdict();
    end
endmodule
`default_nettype wire
